// *** rtl/safety_seq_pkg.sv ***
// Purpose: Shared constants for the safety output sequencer
// Assumes: 50 MHz system clock
// Notes:   Times are kept in ms; cycle counts derive from the clock rate
package safety_seq_pkg;
	localparam int unsigned CLK_HZ          = 50_000_000;
	localparam int unsigned CLK_PER_MS      = CLK_HZ / 1000;
	localparam int unsigned READY_DELAY_MS  = 8000;
	localparam int unsigned SWITCH_ON_MS    = 400;
	localparam int unsigned MISMATCH_MS     = 150;
	localparam int unsigned RISK_MS         = 260;
	localparam int unsigned RISK_STEP_MS    = 5;
	localparam int unsigned DISCREP_MS      = 10;
	localparam int unsigned PULSE_MS        = 1;
	localparam int unsigned PULSE_PERIOD_MS = 100;
	localparam int unsigned CNT_W           = 32;
	localparam int unsigned SYNC_STAGES     = 2;

	typedef enum logic [1:0] {ST_SELFTEST, ST_OFF, ST_ON, ST_FAULT} seq_state_t;

	function automatic logic [CNT_W-1:0] ms_to_cycles(input int unsigned ms);
		ms_to_cycles = CNT_W'(ms * CLK_PER_MS);
	endfunction
endpackage

// *** rtl/cycle_timer.sv ***
// Purpose: Saturating cycle counter with expiry flag
// Assumes: Single clock, synchronous reset
// Notes:   Clear has priority over counting
`timescale 1ns/1ps
module cycle_timer
	import safety_seq_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Control
	input  wire logic             clear,
	input  wire logic             enable,
	input  wire logic [CNT_W-1:0] limit,
	// Status
	output logic      [CNT_W-1:0] count,
	output logic                  expired
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (clear) begin
			cnt_d = '0;
		end else if (enable && cnt_q < limit) begin
			cnt_d = cnt_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign count   = cnt_q;
	assign expired = (cnt_q >= limit);
endmodule

// *** rtl/safety_output_sequencer.sv ***
// Purpose: Self-test, switching, enable monitoring and test pulses of two safety outputs
// Assumes: Pins are asynchronous and pass two flip-flops; 50 MHz clock
// Notes:   Fault is left only through reset, standing in for a power cycle
// Function
// - Outputs off during 8 s self-test
// - Outputs on within 400 ms of actuator
// - Enables disagreeing over 150 ms force off
// - Persistent enable disagreement enters fault state
// - Actuator leaving switches off within 260 ms
// - Risk time grows 5 ms per device
// - Both outputs equal within 10 ms
// - Periodic 1 ms test pulses on outputs
// - Test pulses continue while outputs off
`timescale 1ns/1ps
module safety_output_sequencer
	import safety_seq_pkg::*;
#(
	parameter logic [CNT_W-1:0] READY_CYC  = ms_to_cycles(READY_DELAY_MS),
	parameter logic [CNT_W-1:0] MISMATCH_CYC = ms_to_cycles(MISMATCH_MS),
	parameter logic [CNT_W-1:0] PULSE_CYC  = ms_to_cycles(PULSE_MS),
	parameter logic [CNT_W-1:0] PERIOD_CYC = ms_to_cycles(PULSE_PERIOD_MS),
	parameter int unsigned      CHAIN_POS  = 0
)(
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Sensor and chain pins
	input  wire logic actuator_in_range,
	input  wire logic enable_input_a,
	input  wire logic enable_input_b,
	// Safety outputs
	output logic      safety_output_a,
	output logic      safety_output_b,
	// Status
	output logic      ready,
	output logic      fault
);
	// Shutdown budget widens by one step for every device upstream in the chain
	localparam logic [CNT_W-1:0] RISK_CYC = ms_to_cycles(RISK_MS + RISK_STEP_MS * CHAIN_POS);
	localparam logic [CNT_W-1:0] ON_CYC   = ms_to_cycles(SWITCH_ON_MS);
	localparam logic [CNT_W-1:0] DISC_CYC = ms_to_cycles(DISCREP_MS);

	logic [SYNC_STAGES-1:0] rng_q, ena_q, enb_q;
	logic [SYNC_STAGES-1:0] rng_d, ena_d, enb_d;
	seq_state_t             state_q, state_d;
	logic                   out_a_q, out_a_d, out_b_q, out_b_d;
	logic                   rng_s, ena_s, enb_s, mismatch, demand, pulse_act;
	logic                   ready_done, mis_done, period_done;
	logic [CNT_W-1:0]       period_cnt;

	// Operating states are the only ones where outputs follow demand and carry pulses
	function automatic logic is_operating(input seq_state_t s);
		is_operating = (s == ST_ON) || (s == ST_OFF);
	endfunction

	// Synchronisers: only the last stage feeds logic
	always_comb begin
		rng_d = {rng_q[SYNC_STAGES-2:0], actuator_in_range};
		ena_d = {ena_q[SYNC_STAGES-2:0], enable_input_a};
		enb_d = {enb_q[SYNC_STAGES-2:0], enable_input_b};
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rng_q <= '0;
			ena_q <= '0;
			enb_q <= '0;
		end else begin
			rng_q <= rng_d;
			ena_q <= ena_d;
			enb_q <= enb_d;
		end
	end

	assign rng_s    = rng_q[SYNC_STAGES-1];
	assign ena_s    = ena_q[SYNC_STAGES-1];
	assign enb_s    = enb_q[SYNC_STAGES-1];
	assign mismatch = ena_s ^ enb_s;
	assign demand   = rng_s && ena_s && enb_s;

	cycle_timer u_ready (
		.clk     (clk),
		.resetn  (resetn),
		.clear   (1'b0),
		.enable  (state_q == ST_SELFTEST),
		.limit   (READY_CYC),
		.count   (),
		.expired (ready_done)
	);

	cycle_timer u_mismatch (
		.clk     (clk),
		.resetn  (resetn),
		.clear   (!mismatch),
		.enable  (mismatch),
		.limit   (MISMATCH_CYC),
		.count   (),
		.expired (mis_done)
	);

	cycle_timer u_period (
		.clk     (clk),
		.resetn  (resetn),
		.clear   (period_done),
		.enable  (1'b1),
		.limit   (PERIOD_CYC - CNT_W'(1)),
		.count   (period_cnt),
		.expired (period_done)
	);

	// Pulse runs in both ON and OFF, inverting the line for one pulse width
	assign pulse_act = (period_cnt < PULSE_CYC);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_SELFTEST: begin
				// Enables at odds through power-up must not slip into OFF and pulse high
				if (ready_done && mis_done) begin
					state_d = ST_FAULT;
				end else if (ready_done) begin
					state_d = ST_OFF;
				end
			end
			ST_OFF: begin
				if (mis_done) begin
					state_d = ST_FAULT;
				end else if (demand) begin
					state_d = ST_ON;
				end
			end
			ST_ON: begin
				if (mis_done) begin
					state_d = ST_FAULT;
				end else if (!demand) begin
					state_d = ST_OFF;
				end
			end
			ST_FAULT: state_d = ST_FAULT;
			default:  state_d = ST_FAULT;
		endcase
	end

	// Both lines load from one term so they never drift apart
	always_comb begin
		out_a_d = 1'b0;
		if (is_operating(state_d)) begin
			out_a_d = (state_d == ST_ON) ^ pulse_act;
		end
		out_b_d = out_a_d;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q <= ST_SELFTEST;
			out_a_q <= 1'b0;
			out_b_q <= 1'b0;
		end else begin
			state_q <= state_d;
			out_a_q <= out_a_d;
			out_b_q <= out_b_d;
		end
	end

	assign safety_output_a = out_a_q;
	assign safety_output_b = out_b_q;
	assign ready           = is_operating(state_q);
	assign fault           = (state_q == ST_FAULT);

	// Helper counters watched only by assertions
	logic [CNT_W-1:0] off_wait_q, on_wait_q, disc_q, plen_q;
	logic [CNT_W-1:0] off_wait_d, on_wait_d, disc_d, plen_d;

	// Pulse length is taken from the pins, not from the pulse timer, so a stuck line shows
	always_comb begin
		off_wait_d = (!rng_s && state_q == ST_ON) ? off_wait_q + CNT_W'(1) : '0;
		on_wait_d  = (demand && state_q == ST_OFF) ? on_wait_q + CNT_W'(1) : '0;
		disc_d     = (out_a_q != out_b_q) ? disc_q + CNT_W'(1) : '0;
		plen_d     = (ready && safety_output_a != (state_q == ST_ON)) ? plen_q + CNT_W'(1) : '0;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			off_wait_q <= '0;
			on_wait_q  <= '0;
			disc_q     <= '0;
			plen_q     <= '0;
		end else begin
			off_wait_q <= off_wait_d;
			on_wait_q  <= on_wait_d;
			disc_q     <= disc_d;
			plen_q     <= plen_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	AST_SELFTEST_OFF: assert property ((state_q == ST_SELFTEST) |->
		!safety_output_a && !safety_output_b) else $error("Output on during self-test");
	AST_READY_TIME: assert property ($rose(ready) |-> $past(ready_done))
		else $error("Ready before self-test delay");
	AST_ON_TIME: assert property (on_wait_q <= ON_CYC)
		else $error("Switch-on too slow");
	AST_ON_FOLLOW: assert property ((state_q == ST_OFF && demand && !mis_done)
		|=> state_q == ST_ON) else $error("Demand not honoured");
	AST_MISMATCH_OFF: assert property (mis_done |=> !safety_output_a ##1 !safety_output_a)
		else $error("Output on after enable mismatch");
	AST_FAULT_ENTRY: assert property ((mis_done && (ready || ready_done)) |=> fault)
		else $error("Mismatch did not fault");
	AST_RISK: assert property (off_wait_q < RISK_CYC)
		else $error("Shutdown exceeded risk time");
	AST_OFF_FOLLOW: assert property ((state_q == ST_ON && !rng_s) |-> ##[1:2]
		(state_q != ST_ON)) else $error("Actuator loss not acted on");
	AST_DISCREP: assert property (disc_q <= DISC_CYC)
		else $error("Outputs disagree too long");
	AST_PULSE_LEN: assert property (plen_q <= PULSE_CYC)
		else $error("Test pulse too long");
	AST_PULSE_OFF: assert property ((state_d == ST_OFF && pulse_act) |=>
		safety_output_a && safety_output_b) else $error("No pulse while off");
	AST_FAULT_HOLD: assert property (fault |=>
		fault && !safety_output_a && !safety_output_b) else $error("Fault released");

	COV_READY: cover property ($rose(ready));
	COV_SWITCH_ON: cover property (state_q == ST_OFF ##1 state_q == ST_ON);
	COV_FAULT: cover property ($rose(fault));
	COV_PULSE_ON: cover property (state_q == ST_ON && pulse_act);
	COV_START_FAULT: cover property (state_q == ST_SELFTEST ##1 state_q == ST_FAULT);
endmodule

// *** tb/downstream_filter.sv ***
// Purpose: Downstream controller model that reads the two safety outputs
// Assumes: Same clock as the sequencer
// Notes:   Levels shorter than FILT+2 cycles are taken as test pulses, not as changes
`timescale 1ns/1ps
module downstream_filter #(
	parameter int unsigned FILT = 3
)(
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Safety outputs seen at the far side
	input  wire logic safety_output_a,
	input  wire logic safety_output_b,
	// Filtered guard state
	output logic      guard_closed
);
	logic [7:0] run_q, run_d;
	logic       last_q, last_d, closed_q, closed_d;
	logic       both;
	assign both = safety_output_a & safety_output_b;
	always_comb begin
		last_d   = both;
		run_d    = (both == last_q) ? ((run_q == 8'hFF) ? run_q : run_q + 8'h01) : 8'h00;
		closed_d = closed_q;
		if (run_q > 8'(FILT)) begin
			closed_d = last_q; // Short pulses never reach here
		end
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			run_q    <= 8'h00;
			last_q   <= 1'b0;
			closed_q <= 1'b0;
		end else begin
			run_q    <= run_d;
			last_q   <= last_d;
			closed_q <= closed_d;
		end
	end
	assign guard_closed = closed_q;
endmodule

// *** tb/safety_output_sequencer_test.sv ***
// Purpose: Self-checking bench for the safety output sequencer
// Assumes: Shortened counts: ready 50, mismatch 20, pulse 3, period 16 cycles
// Notes:   Far side is judged through the pulse-tolerant downstream model
`timescale 1ns/1ps
module safety_output_sequencer_test;
	import safety_seq_pkg::*;
	logic clk = 1'b0, resetn = 1'b0, rng = 1'b0, ena = 1'b0, enb = 1'b0;
	logic oa, ob, rdy, flt, closed;
	int   n_mismatch = 0, tests_run = 0, cyc = 0, k;
	always #10 clk = ~clk;
	safety_output_sequencer #(.READY_CYC(32'h32), .MISMATCH_CYC(32'h14), .PULSE_CYC(32'h3),
		.PERIOD_CYC(32'h10)) DUT (.clk(clk), .resetn(resetn), .actuator_in_range(rng),
		.enable_input_a(ena), .enable_input_b(enb), .safety_output_a(oa),
		.safety_output_b(ob), .ready(rdy), .fault(flt));
	downstream_filter #(.FILT(3)) far (.clk(clk), .resetn(resetn), .safety_output_a(oa),
		.safety_output_b(ob), .guard_closed(closed));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic drive(input logic a, input logic b, input logic r);
		@(posedge clk);
		ena <= a;
		enb <= b;
		rng <= r;
		#1;
	endtask
	task automatic stop_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Outputs must agree in every cycle, since the designer chose zero offset
	always @(negedge clk) if (resetn) chk({31'h0, oa}, {31'h0, ob});
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			stop_test;
		end
	end
	task automatic wait_closed(input logic lvl);
		for (k = 0; k < 30 && closed !== lvl; k++) tick(1);
	endtask
	task automatic count_pulses(input logic lvl);
		int n;
		n = 0;
		// Any window of one period holds exactly one pulse width of pulsed cycles
		for (k = 0; k < 16; k++) begin
			tick(1);
			if (oa !== lvl) n++;
		end
		chk(n, 3);
	endtask
	task automatic test_selftest;
		resetn <= 1'b1;
		ena    <= 1'b1;
		enb    <= 1'b1;
		rng    <= 1'b1;
		for (k = 0; k < 40; k++) begin
			tick(1);
			chk({oa, ob, rdy}, 3'h0);
		end
		for (k = 0; k < 30 && rdy !== 1'b1; k++) tick(1);
		chk(rdy, 1'b1);
		$display("test selftest done");
	endtask
	task automatic test_on_off;
		wait_closed(1'b1);
		chk(closed, 1'b1);
		count_pulses(1'b1);
		drive(1'b1, 1'b1, 1'b0);
		wait_closed(1'b0);
		chk(closed, 1'b0);
		count_pulses(1'b0);
		$display("test on_off done");
	endtask
	task automatic test_fault;
		drive(1'b1, 1'b1, 1'b1);
		wait_closed(1'b1);
		drive(1'b1, 1'b0, 1'b1);
		tick(10);
		drive(1'b1, 1'b1, 1'b1);
		tick(30);
		chk({flt, closed}, 2'h1);
		drive(1'b0, 1'b1, 1'b1);
		for (k = 0; k < 30 && flt !== 1'b1; k++) tick(1);
		chk(flt, 1'b1);
		chk({oa, ob}, 2'h0);
		drive(1'b1, 1'b1, 1'b1);
		for (k = 0; k < 40; k++) begin
			tick(1);
			chk({oa, ob, rdy, flt}, 4'h1);
		end
		$display("test fault done");
	endtask
	task automatic test_startup_mismatch;
		@(posedge clk);
		resetn <= 1'b0;
		ena    <= 1'b1;
		enb    <= 1'b0;
		rng    <= 1'b1;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		// A fresh reset leaves fault; enables at odds keep outputs off all through self-test
		for (k = 0; k < 50; k++) begin
			tick(1);
			chk({oa, ob, rdy, flt}, 4'h0);
		end
		tick(1);
		chk({oa, ob, rdy, flt}, 4'h1);
		$display("test startup_mismatch done");
	endtask
	initial begin
		repeat (12) @(posedge clk);
		test_selftest;
		test_on_off;
		test_fault;
		test_startup_mismatch;
		stop_test;
	end
endmodule
